//--- src/hadc_cfg.svh
// Constants of the haptic drive control block.
// Assumes inclusion by bare name from the design files.
`ifndef HADC_CFG_SVH
`define HADC_CFG_SVH
`define HADC_LOAD_OFF        2'h0
`define HADC_LOAD_LRA        2'h1
`define HADC_LOAD_ERM        2'h2
`define HADC_SRC_PWM         1'h0
`define HADC_SRC_HOST        1'h1
`define HADC_CODE_MAX        8'sh7f
`define HADC_CODE_MIN        8'sh81
`define HADC_SQUELCH_PERIODS 512
`define HADC_GAIN_NUM        1135
`define HADC_GAIN_DEN        127000
`define HADC_SLOW_HZ         32000
`define HADC_CLK_HZ          50000000
`define HADC_SLOW_DIV        (`HADC_CLK_HZ / `HADC_SLOW_HZ)
`define HADC_DAC_MID         8'h80
`endif

//--- src/hadc_pkg.sv
// Types of the haptic drive control block.
// Assumes the configuration header is compiled alongside.
package hadc_pkg;
	typedef enum logic [1:0] {
		HADC_ST_OFF   = 2'b00,
		HADC_ST_DRIVE = 2'b01,
		HADC_ST_SQL   = 2'b10,
		HADC_ST_FAULT = 2'b11
	} hadc_state_t;

	typedef struct packed {
		logic [1:0] load_type_select;
		logic       drive_source_select;
		logic       range_config_bit;
		logic [7:0] squelch_window;
		logic [3:0] output_gain_setting;
		logic [3:0] slew_filter_bandwidth;
	} hadc_cfg_t;

	typedef struct packed {
		logic [7:0] dac_code;
		logic       motor_out_pos;
		logic       motor_out_neg;
	} hadc_out_t;
endpackage

//--- src/hadc_pwm_meas.sv
// Measures high time and period of the drive PWM input and maps the duty to a signed code.
// Assumes the PWM input is synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "hadc_cfg.svh"
module hadc_pwm_meas
	import hadc_pkg::*;
#(
	parameter int CW = 20
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              drive_pwm_duty,
	output logic signed [7:0]      pwm_code,
	output logic                   period_tick
);
	logic [CW-1:0] per_cnt_reg;
	logic [CW-1:0] hi_cnt_reg;
	logic          pwm_d_reg;
	logic          rise;
	logic [CW+8:0] scaled;
	logic signed [CW+9:0] offs;

	assign rise = drive_pwm_duty & ~pwm_d_reg;
	assign period_tick = rise;
	// Each 1/256 of the period away from half duty moves the code by one.
	assign scaled = {1'b0, hi_cnt_reg, 8'h00} / {9'h000, per_cnt_reg};
	assign offs = $signed({1'b0, scaled}) - $signed({{(CW+2){1'b0}}, 8'h80});

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwm_d_reg <= 1'b0;
			per_cnt_reg <= '0;
			hi_cnt_reg <= '0;
		end else begin
			pwm_d_reg <= drive_pwm_duty;
			if (rise) begin
				per_cnt_reg <= CW'(1);
				hi_cnt_reg <= CW'(1);
			end else begin
				if (per_cnt_reg != '1) per_cnt_reg <= per_cnt_reg + CW'(1);
				if (drive_pwm_duty && hi_cnt_reg != '1) hi_cnt_reg <= hi_cnt_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwm_code <= 8'sh00;
		end else if (rise && per_cnt_reg > CW'(2)) begin
			if (offs > 127) pwm_code <= `HADC_CODE_MAX;
			else if (offs < -127) pwm_code <= `HADC_CODE_MIN;
			else pwm_code <= 8'(offs);
		end
	end
endmodule
`default_nettype wire

//--- src/hadc_top.sv
// Haptic actuator drive control: code source, squelch, slew filter, gain, DAC code, faults.
// Assumes all inputs synchronous to clk_sys; fault inputs come from analog comparators.
`timescale 1ns/10ps
`default_nettype none
`include "hadc_cfg.svh"
module hadc_top
	import hadc_pkg::*;
#(
	parameter int SLOW_DIV = `HADC_SLOW_DIV,
	parameter int SQL_PER  = `HADC_SQUELCH_PERIODS
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire hadc_cfg_t         cfg,
	input  wire logic signed [7:0] host_amplitude_level,
	input  wire logic              drive_pwm_duty,
	input  wire logic              short_detect,
	input  wire logic              temp_alarm,
	output hadc_out_t              drive_out,
	output logic signed [7:0]      signed_drive_code,
	output logic                   short_fault_flag,
	output logic                   drive_active
);
	hadc_state_t       state_reg;
	logic signed [7:0] pwm_code;
	logic              period_tick;
	logic [15:0]       slow_cnt_reg;
	logic              slow_tick;
	logic              ref_tick;
	logic              enabled;
	logic              is_erm;
	logic              in_sql;
	logic [9:0]        sql_cnt_reg;
	logic signed [7:0] filt_reg;
	logic [7:0]        slew_cnt_reg;
	logic              carrier_reg;
	logic signed [19:0] prod;
	logic signed [7:0] lvl;
	logic [7:0]        mag;

	hadc_pwm_meas #(.CW(20)) u_meas (
		.clk_sys        (clk_sys),
		.rst_n          (rst_n),
		.drive_pwm_duty (drive_pwm_duty),
		.pwm_code       (pwm_code),
		.period_tick    (period_tick)
	);

	assign enabled = cfg.load_type_select != `HADC_LOAD_OFF;
	assign is_erm = cfg.load_type_select == `HADC_LOAD_ERM;
	assign slow_tick = slow_cnt_reg == 16'(SLOW_DIV - 1);
	// Rotating-mass host mode references the slow oscillator; all else the PWM period.
	assign ref_tick = (is_erm && cfg.drive_source_select) ? slow_tick : period_tick;
	assign in_sql = (signed_drive_code <= $signed({1'b0, cfg.squelch_window[6:0]})) &&
		(signed_drive_code >= -$signed({1'b0, cfg.squelch_window[6:0]}));
	assign short_fault_flag = short_detect;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) slow_cnt_reg <= 16'h0000;
		else if (slow_tick) slow_cnt_reg <= 16'h0000;
		else slow_cnt_reg <= slow_cnt_reg + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			signed_drive_code <= 8'sh00;
		end else if (cfg.drive_source_select == `HADC_SRC_PWM) begin
			signed_drive_code <= pwm_code;
		end else if (is_erm ? slow_tick : period_tick) begin
			signed_drive_code <= host_amplitude_level;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) sql_cnt_reg <= 10'h000;
		else if (!in_sql) sql_cnt_reg <= 10'h000;
		else if (ref_tick && sql_cnt_reg <= 10'(SQL_PER)) sql_cnt_reg <= sql_cnt_reg + 10'h001;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= HADC_ST_OFF;
		end else if (!enabled) begin
			state_reg <= HADC_ST_OFF;
		end else if (short_detect || temp_alarm) begin
			state_reg <= HADC_ST_FAULT;
		end else if (sql_cnt_reg > 10'(SQL_PER)) begin
			state_reg <= HADC_ST_SQL;
		end else begin
			state_reg <= HADC_ST_DRIVE;
		end
	end

	// Slew limiter: one code step per (bandwidth+1)*16 cycles, toward the target.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			filt_reg <= 8'sh00;
			slew_cnt_reg <= 8'h00;
		end else if (state_reg != HADC_ST_DRIVE) begin
			filt_reg <= 8'sh00;
			slew_cnt_reg <= 8'h00;
		end else if (slew_cnt_reg >= {cfg.slew_filter_bandwidth, 4'hf}) begin
			slew_cnt_reg <= 8'h00;
			if (filt_reg < signed_drive_code) filt_reg <= filt_reg + 8'sh01;
			else if (filt_reg > signed_drive_code) filt_reg <= filt_reg - 8'sh01;
		end else begin
			slew_cnt_reg <= slew_cnt_reg + 8'h01;
		end
	end

	// Gain: code*gain*1.135 with 127 as full scale; saturates as the supply would.
	// The product is formed at 32 bits, as code*gain*1135 overflows 20 bits.
	assign prod = 20'(($signed({{24{filt_reg[7]}}, filt_reg}) *
		$signed({28'h0000000, cfg.output_gain_setting}) * 32'sd1135) / 32'sd1000);
	assign lvl = (prod > 127) ? 8'sh7f : (prod < -127) ? 8'sh81 : 8'(prod);
	assign mag = lvl[7] ? 8'(-lvl) : 8'(lvl);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) carrier_reg <= 1'b0;
		else if (period_tick) carrier_reg <= ~carrier_reg;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drive_out <= '{dac_code: `HADC_DAC_MID, motor_out_pos: 1'b0, motor_out_neg: 1'b0};
		end else if (state_reg != HADC_ST_DRIVE) begin
			drive_out <= '{dac_code: `HADC_DAC_MID, motor_out_pos: 1'b0, motor_out_neg: 1'b0};
		end else if (is_erm) begin
			drive_out.dac_code <= `HADC_DAC_MID + 8'(lvl);
			drive_out.motor_out_pos <= !lvl[7] && lvl != 8'sh00;
			drive_out.motor_out_neg <= lvl[7];
		end else begin
			drive_out.dac_code <= carrier_reg ? `HADC_DAC_MID + mag : `HADC_DAC_MID - mag;
			drive_out.motor_out_pos <= carrier_reg && mag != 8'h00;
			drive_out.motor_out_neg <= !carrier_reg && mag != 8'h00;
		end
	end

	assign drive_active = state_reg == HADC_ST_DRIVE;

	a_fault_grounds: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(short_detect && enabled) |-> ##2 (!drive_out.motor_out_pos && !drive_out.motor_out_neg))
		else $error("outputs not grounded after short");
	a_off_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!enabled) [*2] |=> !drive_active)
		else $error("drive active while disabled");
	a_temp_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(temp_alarm && enabled) |=> !drive_active)
		else $error("drive active during alarm");
	a_resume_auto: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(enabled && !short_detect && !temp_alarm && sql_cnt_reg == 10'h000) [*2] |-> drive_active)
		else $error("no automatic resume");
	a_sql_force: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sql_cnt_reg > 10'(SQL_PER) && enabled) |=> !drive_active)
		else $error("squelch not applied");
	a_slew_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		drive_active |=> (filt_reg - $past(filt_reg) <= 1 && $past(filt_reg) - filt_reg <= 1))
		else $error("slew step too large");
	a_src_pwm: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.drive_source_select == 1'b0) |=> signed_drive_code == $past(pwm_code))
		else $error("pwm code not followed");
	a_src_host: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.drive_source_select && is_erm && slow_tick) |=>
		signed_drive_code == $past(host_amplitude_level))
		else $error("host level not sampled");
endmodule
`default_nettype wire

//--- testbench/hadc_host_model.sv
// Host side model: drives the PWM input with a set high time and period.
// Assumes hi is below per while run is high.
`timescale 1ns/10ps
`default_nettype none
module hadc_host_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [7:0] hi,
	input  wire logic [7:0] per,
	output logic            pwm
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			pwm     <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 8'h00;
			pwm     <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg >= per - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
			pwm     <= (cnt_reg < hi);
		end
	end
endmodule
`default_nettype wire

//--- testbench/haptic_actuator_drive_control_tb.sv
// Self-checking bench of the haptic drive control block.
// Assumes shortened slow-tick and squelch counts of 4.
`timescale 1ns/10ps
`default_nettype none
module haptic_actuator_drive_control_tb
	import hadc_pkg::*;
;
	logic              clk_sys, rst_n, short_detect, temp_alarm, run, note_rdy, p;
	hadc_cfg_t         cfg;
	logic signed [7:0] lvl, signed_drive_code;
	logic [7:0]        hi;
	logic              pwm, short_fault_flag, drive_active;
	hadc_out_t         drive_out;
	logic [15:0]       lfsr;
	logic [7:0]        notes[$];
	int                bad_count, n_tests, i;
	hadc_host_model u_host (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .hi(hi),
		.per(8'h28), .pwm(pwm));
	hadc_top #(.SLOW_DIV(4), .SQL_PER(4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
		.host_amplitude_level(lvl), .drive_pwm_duty(pwm), .short_detect(short_detect),
		.temp_alarm(temp_alarm), .drive_out(drive_out), .signed_drive_code(signed_drive_code),
		.short_fault_flag(short_fault_flag), .drive_active(drive_active));
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] pwm_exp(input int h);
		int v;
		v = h * 256 / 40 - 128;
		if (v > 127) v = 127;
		if (v < -127) v = -127;
		return v[7:0];
	endfunction
	task automatic final_report;
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk1(input logic e, input logic g);
		chk8({7'h0, e}, {7'h0, g});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic note(input logic [7:0] e);
		notes.push_back(e);
		note_rdy = 1'b1;
		cyc(1);
		note_rdy = 1'b0;
		cyc(1);
	endtask
	task automatic wait_dac(input logic [7:0] e, input int lim);
		for (i = 0; i < lim && drive_out.dac_code !== e; i++) cyc(1);
		chk8(e, drive_out.dac_code);
		if (drive_out.dac_code !== e) final_report();
	endtask
	always @(posedge clk_sys) begin
		if (note_rdy === 1'b1) chk8(notes.pop_front(), signed_drive_code);
	end
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		rst_n = 1'b0; cfg = '0; lvl = 8'sh00; short_detect = 1'b0; temp_alarm = 1'b0;
		run = 1'b0; note_rdy = 1'b0; hi = 8'h14; lfsr = 16'hf6ef;
		bad_count = 0; n_tests = 0;
		cyc(12);
		rst_n = 1'b1;
		cyc(20);
		chk1(1'b0, drive_active);
		chk8(8'h80, drive_out.dac_code);
		cfg.load_type_select = 2'h2;
		cfg.output_gain_setting = 4'hf;
		run = 1'b1;
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			hi = lfsr[0] ? 8'h15 + {4'h0, lfsr[4:1]} : 8'h04 + {4'h0, lfsr[4:1]};
			cyc(2200);
			note(pwm_exp(int'(hi)));
		end
		hi = 8'h27;
		wait_dac(8'hff, 3000);
		short_detect = 1'b1;
		cyc(3);
		chk1(1'b1, short_fault_flag);
		chk8(8'h80, drive_out.dac_code);
		chk1(1'b0, drive_out.motor_out_pos | drive_out.motor_out_neg);
		short_detect = 1'b0;
		wait_dac(8'hff, 3000);
		temp_alarm = 1'b1;
		cyc(3);
		chk1(1'b0, drive_active);
		chk8(8'h80, drive_out.dac_code);
		temp_alarm = 1'b0;
		wait_dac(8'hff, 3000);
		hi = 8'h01;
		wait_dac(8'h01, 5000);
		chk1(1'b1, drive_out.motor_out_neg);
		chk1(1'b0, drive_out.motor_out_pos);
		run = 1'b0;
		cfg.drive_source_select = 1'b1;
		cfg.range_config_bit = 1'b1;
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			lvl = (lfsr[7:0] == 8'h80 || lfsr[7:0] == 8'h00) ? 8'sh41 : lfsr[7:0];
			cyc(2200);
			note(lvl);
		end
		cfg.squelch_window = 8'h10;
		lvl = 8'sh05;
		cyc(100);
		chk8(8'h80, drive_out.dac_code);
		chk1(1'b0, drive_active);
		cfg.load_type_select = 2'h1;
		run = 1'b1;
		lvl = 8'sh7f;
		cyc(2200);
		note(8'h7f);
		p = drive_out.motor_out_pos;
		cyc(40);
		chk1(~p, drive_out.motor_out_pos);
		chk1(p, drive_out.motor_out_neg);
		chk8(p ? 8'h01 : 8'hff, drive_out.dac_code);
		final_report();
	end
endmodule
`default_nettype wire
